// ### core/dih_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Word registers on a 32-bit bus, byte address = 4 * index
// Notes:   Definitions only
`ifndef DIH_MAP_SVH
`define DIH_MAP_SVH

// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define DIH_IDX_EVENT_FLAGS 6'h04
`define DIH_IDX_LINE_HOOK 6'h05
`define DIH_IDX_CONFIG 6'h20
`define DIH_IDX_MASK 6'h21

// ---------------------------------------------------------------
// Event flag and mask bit positions
// ---------------------------------------------------------------
`define DIH_EF_RING 7
`define DIH_EF_ROVL 6
`define DIH_EF_FRAME 5
`define DIH_EF_BILL 4
`define DIH_EF_DROP 3
`define DIH_EF_LOOP 2
`define DIH_EF_POL 0
`define DIH_EF_IMPL 8'hfd

// ---------------------------------------------------------------
// Line hook control bit positions
// ---------------------------------------------------------------
`define DIH_LH_RNEG 6
`define DIH_LH_RPOS 5
`define DIH_LH_MON 3
`define DIH_LH_RSTAT 2
`define DIH_LH_OFFH 0

// ---------------------------------------------------------------
// Configuration bit positions
// ---------------------------------------------------------------
`define DIH_CF_GIE 0
`define DIH_CF_EDGE 1
`define DIH_CF_FWAVE 2
`define DIH_CF_HPE 3
`define DIH_CF_WDOG 4
`define DIH_CF_PDL 5
`define DIH_CF_IMPL 8'h3f
`define DIH_CF_STICKY 8'h10

// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define DIH_FLAGS_RST 8'h00
`define DIH_MASK_RST 8'h00
`define DIH_CFG_RST 8'h00
`define DIH_LCS_MAX 5'h1f

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DIH_CLK_HZ 100000000
`define DIH_RING_HOLD_S 5
`define DIH_WDOG_S 4

`endif

// ### core/dih_pkg.sv
// Purpose: Types shared by the hook and event logic
// Assumes: Constants live in dih_map.svh
// Notes:   Line inputs travel as one packed struct
package dih_pkg;

   typedef struct packed {
      logic ring_positive_live;
      logic ring_negative_live;
      logic rx_level_excess;
      logic frame_locked;
      logic billing_tone_seen;
      logic dropout_status;
      logic [4:0] loop_current_sense;
      logic line_voltage_sign;
   } dih_line_evt_t;

endpackage

// ### core/dih_sync.sv
// Purpose: Two-stage synchroniser for line-side levels
// Assumes: Inputs are asynchronous levels
// Notes:   Only the second stage leaves the module
`timescale 1ns/1ps
module dih_sync #(
   parameter int W = 13,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

// ### core/dih_hold_timer.sv
// Purpose: Down counter that pulses after LIMIT idle cycles
// Assumes: restart and enable are on the mclk domain
// Notes:   Held off while disabled, so it starts fresh on enable
`timescale 1ns/1ps
module dih_hold_timer #(
   parameter int unsigned LIMIT = 100
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic restart,
   output logic expired
);

   localparam logic [31:0] LOAD = 32'(LIMIT - 1);

   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic exp_q;
   logic exp_d;

   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (!enable || restart) begin
         cnt_d = LOAD;
      end else if (cnt_q == 32'h0) begin
         exp_d = 1'b1;
         cnt_d = LOAD;
      end else begin
         cnt_d = cnt_q - 32'h1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= LOAD;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;

endmodule

// ### core/dih_ctrl.sv
// Purpose: Event flags, interrupt gate and hook control
// Assumes: Classic Wishbone slave, 8-bit registers in low byte
// Notes:   Line inputs are asynchronous and synchronised here
// What this block does, and what software must do
// [RQ1] Ring detection sets ring flag bit 7
// [RQ2] Interrupt when flag, mask and enable set
// [RQ3] Flags stay set until written zero
// [RQ4] Edge mode: ring start or both edges
// [RQ5] Software clears ring/dropout after power-up
// [RQ6] Overload sets bit 6; clear clears status
// [RQ7] Missing frame lock sets bit 5
// [RQ8] Billing tone sets bit 4
// [RQ9] Supply dropout sets bit 3
// [RQ10] Loop current all ones sets bit 2
// [RQ11] Software checks overcurrent after loop flag
// [RQ12] Line voltage sign change sets bit 0
// [RQ13] Reserved bits read as zero
// [RQ14] Live ring polarity on control bits 6,5
// [RQ15] Control bit 3 enables on-hook monitoring
// [RQ16] Ring status holds 5 s, off-hook clears
// [RQ17] Full-wave select decides qualifying ring polarity
// [RQ18] Off-hook bit ORed with enabled pin
// [RQ19] Software clears start flag before burst end
// [RQ20] Watchdog expiry clears the off-hook bit
// [RQ21] Writing one leaves a flag unchanged
`timescale 1ns/1ps
`include "dih_map.svh"
module dih_ctrl
   import dih_pkg::*;
#(
   parameter int unsigned RING_HOLD_CYC =
      `DIH_RING_HOLD_S * `DIH_CLK_HZ,
   parameter int unsigned WDOG_CYC = `DIH_WDOG_S * `DIH_CLK_HZ
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire dih_line_evt_t line_evt_i,
   input wire logic off_hook_pin,
   output logic irq_o,
   output logic off_hook_o,
   output logic line_monitor_o,
   output logic line_side_powerdown_o,
   output logic receive_overload_status_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic is_reg(input logic [5:0] a,
                                   input logic [5:0] b);
      return a == b;
   endfunction

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   localparam int SW = $bits(dih_line_evt_t) + 1;
   // Idle line on reset, so no false frame loss right after it
   localparam dih_line_evt_t EVT_IDLE = '{frame_locked: 1'b1, default: '0};
   localparam logic [SW-1:0] SYNC_IDLE = {EVT_IDLE, 1'b0};

   logic [SW-1:0] sync_out;
   dih_line_evt_t s;
   logic pin_s;

   dih_sync #(.W(SW), .RST_VAL(SYNC_IDLE)) u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .d({line_evt_i, off_hook_pin}),
      .q(sync_out)
   );

   assign s = dih_line_evt_t'(sync_out[SW-1:1]);
   assign pin_s = sync_out[0];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0] flags_q, flags_d;
   logic [7:0] mask_q, mask_d;
   logic [7:0] cfg_q, cfg_d;
   logic ohreq_q, ohreq_d;
   logic mon_q, mon_d;
   logic rstat_q, rstat_d;
   logic rov_q, rov_d;
   logic ring_any_q, ring_any_d;
   logic lvs_q, lvs_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic irq_q, irq_d;
   logic offh_q, offh_d;

   logic acc, wr, wr_any;
   logic [5:0] idx;
   logic [7:0] wdat;
   logic [7:0] evt_set;
   logic ring_any, ring_start, ring_end, ring_qual;
   logic offhook_eff;
   logic ring_expire, wdog_expire;

   // ---------------------------------------------------------------
   // Bus decode and event detection
   // ---------------------------------------------------------------
   always_comb begin
      acc = wb_cyc_i & wb_stb_i & ~ack_q;
      wr_any = acc & wb_we_i;
      wr = wr_any & wb_sel_i[0];
      idx = wb_adr_i[7:2];
      wdat = wb_dat_i[7:0];
      ring_any = s.ring_positive_live | s.ring_negative_live;
      ring_start = ring_any & ~ring_any_q;
      ring_end = ~ring_any & ring_any_q;
      // [RQ17] Qualifying ring polarity
      ring_qual = s.ring_positive_live |
                  (cfg_q[`DIH_CF_FWAVE] & s.ring_negative_live);
      // [RQ18] Request ORed with pin
      offhook_eff = ohreq_q | (cfg_q[`DIH_CF_HPE] & pin_s);
      evt_set = 8'h00;
      // [RQ1] Ring start sets flag
      // [RQ4] End edge only in two-edge mode
      evt_set[`DIH_EF_RING] = ring_start |
                              (cfg_q[`DIH_CF_EDGE] & ring_end);
      // [RQ6] Excess receive level
      evt_set[`DIH_EF_ROVL] = s.rx_level_excess;
      // [RQ7] No frame lock
      evt_set[`DIH_EF_FRAME] = ~s.frame_locked;
      // [RQ8] Billing tone seen
      evt_set[`DIH_EF_BILL] = s.billing_tone_seen;
      // [RQ9] Supply collapse
      evt_set[`DIH_EF_DROP] = s.dropout_status;
      // [RQ10] Loop current at maximum
      evt_set[`DIH_EF_LOOP] = s.loop_current_sense == `DIH_LCS_MAX;
      // [RQ12] Sign change either way
      evt_set[`DIH_EF_POL] = s.line_voltage_sign ^ lvs_q;
   end

   // ---------------------------------------------------------------
   // Timers
   // ---------------------------------------------------------------
   dih_hold_timer #(.LIMIT(RING_HOLD_CYC)) u_ring_hold (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .enable(rstat_q),
      .restart(ring_qual),
      .expired(ring_expire)
   );

   // Any register write restarts the watchdog
   dih_hold_timer #(.LIMIT(WDOG_CYC)) u_wdog (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .enable(cfg_q[`DIH_CF_WDOG]),
      .restart(wr_any),
      .expired(wdog_expire)
   );

   // ---------------------------------------------------------------
   // Register next state
   // ---------------------------------------------------------------
   always_comb begin
      flags_d = flags_q;
      // [RQ3] Write zero clears, only then
      // [RQ21] Ones leave flags alone
      if (wr && is_reg(idx, `DIH_IDX_EVENT_FLAGS)) begin
         flags_d = flags_q & wdat;
      end
      // Set wins over a clear in the same cycle
      // [RQ13] Bit 1 never stored
      flags_d = (flags_d | evt_set) & `DIH_EF_IMPL;

      rov_d = rov_q;
      // [RQ6] Clearing the flag clears status
      if (wr && is_reg(idx, `DIH_IDX_EVENT_FLAGS) &&
          !wdat[`DIH_EF_ROVL]) begin
         rov_d = 1'b0;
      end
      if (s.rx_level_excess) begin
         rov_d = 1'b1;
      end

      mask_d = mask_q;
      if (wr && is_reg(idx, `DIH_IDX_MASK)) begin
         mask_d = wdat & `DIH_EF_IMPL;
      end

      cfg_d = cfg_q;
      // Watchdog enable only leaves through reset
      if (wr && is_reg(idx, `DIH_IDX_CONFIG)) begin
         cfg_d = (wdat & `DIH_CF_IMPL) | (cfg_q & `DIH_CF_STICKY);
      end

      ohreq_d = ohreq_q;
      mon_d = mon_q;
      // [RQ20] Timeout drops to on-hook
      if (wdog_expire) begin
         ohreq_d = 1'b0;
      end
      if (wr && is_reg(idx, `DIH_IDX_LINE_HOOK)) begin
         // [RQ18] Software off-hook request
         ohreq_d = wdat[`DIH_LH_OFFH];
         // [RQ15] On-hook monitor enable
         mon_d = wdat[`DIH_LH_MON];
      end

      // [RQ16] Hold, time out, off-hook clear
      rstat_d = rstat_q;
      if (ring_expire) begin
         rstat_d = 1'b0;
      end
      if (ring_qual) begin
         rstat_d = 1'b1;
      end
      if (offhook_eff) begin
         rstat_d = 1'b0;
      end

      ring_any_d = ring_any;
      lvs_d = s.line_voltage_sign;

      // [RQ2] Flag, mask and global enable
      irq_d = cfg_q[`DIH_CF_GIE] & (|(flags_q & mask_q));
      offh_d = offhook_eff;
   end

   // ---------------------------------------------------------------
   // Bus answer
   // ---------------------------------------------------------------
   always_comb begin
      ack_d = acc;
      rdat_d = 32'h0;
      if (acc && !wb_we_i) begin
         case (idx)
            `DIH_IDX_EVENT_FLAGS: rdat_d[7:0] = flags_q;
            `DIH_IDX_LINE_HOOK: begin
               // [RQ14] Live ring polarity
               rdat_d[`DIH_LH_RNEG] = s.ring_negative_live;
               rdat_d[`DIH_LH_RPOS] = s.ring_positive_live;
               rdat_d[`DIH_LH_MON] = mon_q;
               rdat_d[`DIH_LH_RSTAT] = rstat_q;
               rdat_d[`DIH_LH_OFFH] = ohreq_q;
            end
            `DIH_IDX_CONFIG: rdat_d[7:0] = cfg_q;
            `DIH_IDX_MASK: rdat_d[7:0] = mask_q;
            default: rdat_d = 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_q <= `DIH_FLAGS_RST;
         mask_q <= `DIH_MASK_RST;
         cfg_q <= `DIH_CFG_RST;
         ohreq_q <= 1'b0;
         mon_q <= 1'b0;
         rstat_q <= 1'b0;
         rov_q <= 1'b0;
         ring_any_q <= 1'b0;
         lvs_q <= 1'b0;
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
         irq_q <= 1'b0;
         offh_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         mask_q <= mask_d;
         cfg_q <= cfg_d;
         ohreq_q <= ohreq_d;
         mon_q <= mon_d;
         rstat_q <= rstat_d;
         rov_q <= rov_d;
         ring_any_q <= ring_any_d;
         lvs_q <= lvs_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         irq_q <= irq_d;
         offh_q <= offh_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign irq_o = irq_q;
   assign off_hook_o = offh_q;
   assign line_monitor_o = mon_q;
   assign line_side_powerdown_o = cfg_q[`DIH_CF_PDL];
   assign receive_overload_status_o = rov_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_ring_start_set: // [RQ1]
      assert property (@(posedge mclk) disable iff (sys_rst)
         ring_start |=> flags_q[`DIH_EF_RING])
      else $error("ring start did not set ring flag");

   a_irq_gate: // [RQ2]
      assert property (@(posedge mclk) disable iff (sys_rst)
         ##1 irq_q == ($past(cfg_q[`DIH_CF_GIE]) &&
                       |($past(flags_q) & $past(mask_q))))
      else $error("interrupt output does not follow gate");

   a_flag_sticky: // [RQ3]
      assert property (@(posedge mclk) disable iff (sys_rst)
         (flags_q[`DIH_EF_BILL] &&
          !(wr && is_reg(idx, `DIH_IDX_EVENT_FLAGS)))
         |=> flags_q[`DIH_EF_BILL])
      else $error("flag fell without a clearing write");

   a_ring_end_edge: // [RQ4]
      assert property (@(posedge mclk) disable iff (sys_rst)
         (ring_end && cfg_q[`DIH_CF_EDGE]) |=> flags_q[`DIH_EF_RING])
      else $error("two-edge mode missed ring end");

   a_rov_clear_pair: // [RQ6]
      assert property (@(posedge mclk) disable iff (sys_rst)
         (wr && is_reg(idx, `DIH_IDX_EVENT_FLAGS) &&
          !wdat[`DIH_EF_ROVL] && !s.rx_level_excess)
         |=> !rov_q && !flags_q[`DIH_EF_ROVL])
      else $error("overload clear did not clear status");

   a_frame_loss_set: // [RQ7]
      assert property (@(posedge mclk) disable iff (sys_rst)
         !s.frame_locked |=> flags_q[`DIH_EF_FRAME])
      else $error("frame loss not flagged");

   a_loop_max_set: // [RQ10]
      assert property (@(posedge mclk) disable iff (sys_rst)
         (s.loop_current_sense == `DIH_LCS_MAX)
         |=> flags_q[`DIH_EF_LOOP])
      else $error("loop overload not flagged");

   a_reserved_zero: // [RQ13]
      assert property (@(posedge mclk) disable iff (sys_rst)
         !flags_q[1] && !mask_q[1] && rdat_q[31:8] == 24'h0)
      else $error("reserved bit reads nonzero");

   a_ring_offhook: // [RQ16]
      assert property (@(posedge mclk) disable iff (sys_rst)
         offhook_eff |=> !rstat_q)
      else $error("ring status survived off-hook");

   a_offhook_drive: // [RQ18]
      assert property (@(posedge mclk) disable iff (sys_rst)
         (ohreq_q || (cfg_q[`DIH_CF_HPE] && pin_s)) |=> off_hook_o)
      else $error("off-hook output not driven");

   a_wdog_onhook: // [RQ20]
      assert property (@(posedge mclk) disable iff (sys_rst)
         (wdog_expire && !(wr && is_reg(idx, `DIH_IDX_LINE_HOOK)))
         |=> !ohreq_q)
      else $error("watchdog expiry left line off-hook");

endmodule

// ### verification/dih_host_model.sv
// Purpose: Host side of the register bus, classic Wishbone master
// Assumes: Slave acks some cycles after the request edge
// Notes:   Waits on ack without a count; the bench timeout ends a hang
`timescale 1ns/1ps
module dih_host_model (
   input wire logic mclk,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i
);
   // ---------------------------------------------------------------
   // Idle bus
   // ---------------------------------------------------------------
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0;
   end

   // ---------------------------------------------------------------
   // One classic single cycle
   // ---------------------------------------------------------------
   // Request held until the edge that samples ack, then released
   task automatic xfer(input logic we, input logic [7:0] adr,
                       input logic [7:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= {24'h0, wd};
      do @(posedge mclk); while (wb_ack_i !== 1'b1);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
   endtask
endmodule

// ### verification/tb_dih_ctrl.sv
// Purpose: Self-checking bench for the event flags and hook control
// Assumes: Short hold and watchdog counts set at the instance
// Notes:   Line inputs change on clock edges; sync delay is waited out
`timescale 1ns/1ps
`include "dih_map.svh"
module tb_dih_ctrl
   import dih_pkg::*;
;
   localparam logic [7:0] A_EF = {`DIH_IDX_EVENT_FLAGS, 2'b00};
   localparam logic [7:0] A_LH = {`DIH_IDX_LINE_HOOK, 2'b00};
   localparam logic [7:0] A_CF = {`DIH_IDX_CONFIG, 2'b00};
   localparam logic [7:0] A_MK = {`DIH_IDX_MASK, 2'b00};
   localparam logic [7:0] A_NONE = 8'hfc;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic off_hook_pin = 1'b0;
   dih_line_evt_t line_evt = '{frame_locked: 1'b1, default: '0};
   logic wb_cyc, wb_stb, wb_we, wb_ack, irq_o, off_hook_o;
   logic line_monitor_o, line_side_powerdown_o, rx_ovl_status_o;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat;
   int error_cnt = 0;
   int check_count = 0;
   int cycle_cnt = 0;
   int bitpos[7] = '{7, 6, 5, 4, 3, 2, 0};

   always #5 mclk = ~mclk;

   dih_ctrl #(.RING_HOLD_CYC(50), .WDOG_CYC(40)) dih_ctrl_i (
      .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .line_evt_i(line_evt),
      .off_hook_pin(off_hook_pin), .irq_o(irq_o),
      .off_hook_o(off_hook_o), .line_monitor_o(line_monitor_o),
      .line_side_powerdown_o(line_side_powerdown_o),
      .receive_overload_status_o(rx_ovl_status_o));

   dih_host_model dih_host_model_i (
      .mclk(mclk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
      .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
      .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Generous: the whole run needs about seven hundred cycles
   always @(posedge mclk) begin
      cycle_cnt <= cycle_cnt + 1;
      if (cycle_cnt == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      dih_host_model_i.xfer(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
      logic [31:0] x;
      dih_host_model_i.xfer(1'b0, a, 8'h00, x);
      chk_reg(nm, {24'h0, e}, x);
   endtask

   // Six cycles cover the two-stage sync and the flag register
   task automatic set_evt(input int k, input logic on);
      @(posedge mclk);
      case (k)
         0: line_evt.ring_positive_live <= on;
         1: line_evt.rx_level_excess <= on;
         2: line_evt.frame_locked <= ~on;
         3: line_evt.billing_tone_seen <= on;
         4: line_evt.dropout_status <= on;
         5: line_evt.loop_current_sense <= on ? 5'h1f : 5'h00;
         6: line_evt.line_voltage_sign <= on;
         default: line_evt.ring_negative_live <= on;
      endcase
      repeat (6) @(posedge mclk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd_chk("flags rst", A_EF, 8'h00);
      rd_chk("hook rst", A_LH, 8'h00);
      rd_chk("cfg rst", A_CF, 8'h00);
      rd_chk("mask rst", A_MK, 8'h00);
      wr(A_NONE, 8'hff);
      rd_chk("unmapped", A_NONE, 8'h00);
      wr(A_CF, 8'h20);
      chk_pin("powerdown", 1'b1, line_side_powerdown_o);
      wr(A_CF, 8'h00); // power up before flag clears
   endtask

   task automatic t_flags();
      logic [7:0] m;
      @(posedge mclk);
      line_evt.loop_current_sense <= 5'h1e;
      repeat (6) @(posedge mclk);
      rd_chk("lcs below max", A_EF, 8'h00);
      @(posedge mclk);
      line_evt.loop_current_sense <= 5'h00;
      for (int k = 0; k < 7; k++) begin
         m = 8'h01 << bitpos[k];
         set_evt(k, 1'b1);
         set_evt(k, 1'b0);
         rd_chk("flag sticky", A_EF, m);
         rd_chk("flag still set", A_EF, m);
         wr(A_EF, 8'hff);
         rd_chk("flag write one", A_EF, m);
         wr(A_EF, ~m);
         rd_chk("flag cleared", A_EF, 8'h00);
      end
   endtask

   task automatic t_overload();
      set_evt(1, 1'b1);
      chk_pin("ovl status", 1'b1, rx_ovl_status_o);
      set_evt(1, 1'b0);
      wr(A_EF, 8'hbf);
      repeat (3) @(posedge mclk);
      chk_pin("ovl status clr", 1'b0, rx_ovl_status_o);
   endtask

   task automatic t_irq();
      wr(A_MK, 8'hff);
      rd_chk("mask rb", A_MK, 8'hfd);
      wr(A_CF, 8'h01);
      set_evt(3, 1'b1);
      set_evt(3, 1'b0);
      chk_pin("irq on", 1'b1, irq_o);
      wr(A_MK, 8'hef);
      repeat (3) @(posedge mclk);
      chk_pin("irq masked", 1'b0, irq_o);
      wr(A_MK, 8'hff);
      repeat (3) @(posedge mclk);
      chk_pin("irq unmasked", 1'b1, irq_o);
      wr(A_CF, 8'h00);
      repeat (3) @(posedge mclk);
      chk_pin("irq gie off", 1'b0, irq_o);
      wr(A_CF, 8'h01);
      wr(A_EF, 8'hef);
      repeat (3) @(posedge mclk);
      chk_pin("irq cleared", 1'b0, irq_o);
      wr(A_CF, 8'h00);
      wr(A_MK, 8'h00);
   endtask

   task automatic t_ring_edge();
      for (int md = 0; md < 2; md++) begin
         wr(A_CF, md ? 8'h02 : 8'h00);
         set_evt(0, 1'b1);
         rd_chk("ring start", A_EF, 8'h80);
         wr(A_EF, 8'h7f); // cleared inside the burst
         set_evt(0, 1'b0);
         rd_chk("ring end", A_EF, md ? 8'h80 : 8'h00);
         wr(A_EF, 8'h7f);
      end
      wr(A_CF, 8'h00);
   endtask

   task automatic t_ring_status();
      repeat (70) @(posedge mclk);
      set_evt(7, 1'b1);
      rd_chk("neg half wave", A_LH, 8'h40);
      set_evt(7, 1'b0);
      set_evt(0, 1'b1);
      rd_chk("pos ring", A_LH, 8'h24);
      set_evt(0, 1'b0);
      rd_chk("ring hold", A_LH, 8'h04);
      repeat (70) @(posedge mclk);
      rd_chk("ring expired", A_LH, 8'h00);
      wr(A_CF, 8'h04);
      set_evt(7, 1'b1);
      set_evt(7, 1'b0);
      rd_chk("neg full wave", A_LH, 8'h04);
      wr(A_LH, 8'h01);
      rd_chk("offhook clears", A_LH, 8'h01);
      wr(A_LH, 8'h00);
      wr(A_EF, 8'h00);
      wr(A_CF, 8'h00);
   endtask

   task automatic t_hook();
      wr(A_LH, 8'hff);
      repeat (2) @(posedge mclk);
      chk_pin("monitor", 1'b1, line_monitor_o);
      chk_pin("offhook req", 1'b1, off_hook_o);
      rd_chk("hook rb", A_LH, 8'h09);
      wr(A_LH, 8'h00);
      @(posedge mclk);
      off_hook_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      chk_pin("pin disabled", 1'b0, off_hook_o);
      wr(A_CF, 8'h08);
      repeat (3) @(posedge mclk);
      chk_pin("pin enabled", 1'b1, off_hook_o);
      rd_chk("req independent", A_LH, 8'h00);
      @(posedge mclk);
      off_hook_pin <= 1'b0;
      wr(A_CF, 8'h00);
   endtask

   task automatic t_watchdog();
      wr(A_CF, 8'h10);
      wr(A_LH, 8'h01);
      repeat (20) @(posedge mclk);
      chk_pin("wdog running", 1'b1, off_hook_o);
      repeat (40) @(posedge mclk);
      chk_pin("wdog expired", 1'b0, off_hook_o);
      rd_chk("wdog req clr", A_LH, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_flags();
      t_overload();
      t_irq();
      t_ring_edge();
      t_ring_status();
      t_hook();
      t_watchdog();
      tally_and_finish();
   end
endmodule
